// >>> src/mdi_regs.vh
/*
  register map, field positions and timing counts of the motor driver i2c target.
  assumes a 20 MHz system clock; included by bare name.
*/
`ifndef MDI_REGS_VH
`define MDI_REGS_VH
`define MDI_TARGET_ADDR      7'h52
`define MDI_DEV_CTRL_ADDR    8'h02
`define MDI_NV_CTRL_ADDR     8'h03
`define MDI_SUPPLY_ADDR      8'h1A
`define MDI_UNLOCK_ADDR      8'h03
`define MDI_PARAM_FIRST      8'h20
`define MDI_PARAM_LAST       8'h2B
`define MDI_PARAM_COUNT      12
`define MDI_PROGRAM_KEY      8'hB6
`define MDI_STORE_BIT        6
`define MDI_RELOAD_BIT       5
`define MDI_UNLOCK_BIT       7
`define MDI_STORE_VALUE      8'h50
`define MDI_STORE_TIME_MS    24
`define MDI_CLOCK_KHZ        20000
`define MDI_STORE_CYCLES     (`MDI_STORE_TIME_MS * `MDI_CLOCK_KHZ)
`endif

// >>> src/mdi_nv_mem.v
/*
  twelve byte nonvolatile store model with registered read data.
  assumes one write or one read per cycle, driven by the register core.
*/
`timescale 1ns/1ps
`default_nettype none
module mdi_nv_mem (
  input  wire       clock,
  input  wire       clkEn,
  input  wire       wrEn,
  input  wire [3:0] addr,
  input  wire [7:0] wrData,
  output reg  [7:0] rdData
);
  reg [7:0] cells [0:11];
  // write port and registered read port
  always @(posedge clock) begin
    if (clkEn) begin
      if (wrEn && addr < 4'hC) begin
        cells[addr] <= wrData;
      end
      rdData <= (addr < 4'hC) ? cells[addr] : 8'h00;
    end
  end
endmodule
`default_nettype wire

// >>> src/mdi_i2c_target.v
/*
  i2c target with parameter registers and nonvolatile store and reload.
  assumes scl and sda come from pins, sampled at 20 MHz; the bus pulls sda up.
*/
// Behaviour
// - answer only target address 1010 010
// - parameter writes ignored while unlock clear
// - twelve parameters at 0x20 through 0x2B
// - motor logic uses live register contents
// - key discarded unless next write triggers store
// - store lasts 24 ms, then trigger self clears
// - registers load from store at power up
// - reload bit copies store, then self clears
// - store itself has no read path
// - reads return current register contents anytime
// - supply level code scales by 30 or 22.8 V/256
`timescale 1ns/1ps
`default_nettype none
`include "mdi_regs.vh"
module mdi_i2c_target #(
  parameter STORE_CYCLES = `MDI_STORE_CYCLES
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        clkEn,
  input  wire        sclIn,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOe_n,
  input  wire [7:0]  supplyLevelReading,
  output wire [95:0] motorParams,
  output wire        storeBusy
);
  // bus engine states
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK  = 3'd2;
  localparam ST_WRX  = 3'd3;
  localparam ST_RDX  = 3'd4;
  localparam ST_RACK = 3'd5;

  // store and reload sequencer states
  localparam NV_IDLE  = 2'd0;
  localparam NV_LOAD  = 2'd1;
  localparam NV_STORE = 2'd2;

  // two flop synchronisers and edge history
  reg [1:0] sclSync_reg;
  reg [1:0] sdaSync_reg;
  reg       sclPrev_reg;
  reg       sdaPrev_reg;
  always @(posedge clock) begin
    if (sys_rst) begin
      sclSync_reg <= 2'h3;
      sdaSync_reg <= 2'h3;
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else if (clkEn) begin
      sclSync_reg <= {sclSync_reg[0], sclIn};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclPrev_reg <= sclSync_reg[1];
      sdaPrev_reg <= sdaSync_reg[1];
    end
  end
  // edges seen one cycle after the second flop
  wire scl       = sclSync_reg[1];
  wire sda       = sdaSync_reg[1];
  wire sclRise   = scl && !sclPrev_reg;
  wire sclFall   = !scl && sclPrev_reg;
  wire startCond = scl && sclPrev_reg && !sda && sdaPrev_reg;
  wire stopCond  = scl && sclPrev_reg && sda && !sdaPrev_reg;


  // register state
  reg [7:0]  params_reg [0:11];
  reg [7:0]  devCtrl_reg;
  // unlock gates parameter writes; key waits for the store bit
  reg        unlock_reg;
  reg        keyOk_reg;
  reg        storeTrig_reg;
  reg        reloadTrig_reg;
  // transfer engine
  reg [7:0]  regPtr_reg;
  reg        firstByte_reg;
  reg [2:0]  state_reg;
  reg [7:0]  shift_reg;
  reg [2:0]  bitCnt_reg;
  reg        readDir_reg;
  reg        ackDrive_reg;
  reg        dataDrive_reg;
  // store and reload sequencer
  reg [1:0]  nvState_reg;
  reg [3:0]  nvIdx_reg;
  reg        nvLoadWr_reg;
  reg [3:0]  nvLoadIdx_reg;
  reg [31:0] nvTimer_reg;


  // nonvolatile interface
  // cells are written in the first twelve cycles, then the timer runs
  wire       nvWrEn   = (nvState_reg == NV_STORE) && (nvTimer_reg == 32'h0) && (nvIdx_reg < 4'hC);
  wire [7:0] nvRdData;
  mdi_nv_mem nvMem (
    .clock  (clock),
    .clkEn  (clkEn),
    .wrEn   (nvWrEn),
    .addr   (nvIdx_reg),
    .wrData (params_reg[nvIdx_reg]),
    .rdData (nvRdData)
  );


  // read mux over current registers, store never read directly
  // reserved bits of the store control read as zero
  reg [7:0] readByte;
  always @* begin
    readByte = 8'h00;
    if (regPtr_reg >= `MDI_PARAM_FIRST && regPtr_reg <= `MDI_PARAM_LAST) begin
      readByte = params_reg[regPtr_reg[3:0] - 4'h0];
    end else if (regPtr_reg == `MDI_DEV_CTRL_ADDR) begin
      readByte = devCtrl_reg;
    end else if (regPtr_reg == `MDI_NV_CTRL_ADDR) begin
      readByte = {unlock_reg, storeTrig_reg, reloadTrig_reg, 5'h00};
    end else if (regPtr_reg == `MDI_SUPPLY_ADDR) begin
      readByte = supplyLevelReading;
    end
  end
  wire [3:0] paramIdx = regPtr_reg[3:0] + ((regPtr_reg[4]) ? 4'h0 : 4'h0);


  // data byte received from controller
  wire       byteDone  = sclRise && bitCnt_reg == 3'd7;
  wire [7:0] rxByte    = {shift_reg[6:0], sda};
  reg        wrStrobe;
  always @* begin
    wrStrobe = (state_reg == ST_WRX) && byteDone && !firstByte_reg;
  end


  // bus engine and register writes
  integer i;
  always @(posedge clock) begin
    if (sys_rst) begin
      state_reg      <= ST_IDLE;
      shift_reg      <= 8'h00;
      bitCnt_reg     <= 3'd0;
      readDir_reg    <= 1'b0;
      ackDrive_reg   <= 1'b0;
      dataDrive_reg  <= 1'b0;
      regPtr_reg     <= 8'h00;
      firstByte_reg  <= 1'b0;
      devCtrl_reg    <= 8'h00;
      unlock_reg     <= 1'b0;
      keyOk_reg      <= 1'b0;
      storeTrig_reg  <= 1'b0;
      reloadTrig_reg <= 1'b1; // load from store after power up
      nvState_reg    <= NV_IDLE;
      nvIdx_reg      <= 4'h0;
      nvLoadWr_reg   <= 1'b0;
      nvLoadIdx_reg  <= 4'h0;
      nvTimer_reg    <= 32'h0;
      for (i = 0; i < 12; i = i + 1) begin
        params_reg[i] <= 8'h00;
      end
    end else if (clkEn) begin
      // protocol
      if (stopCond) begin
        state_reg     <= ST_IDLE;
        ackDrive_reg  <= 1'b0;
        dataDrive_reg <= 1'b0;
      end else if (startCond) begin
        state_reg     <= ST_ADDR;
        bitCnt_reg    <= 3'd0;
        ackDrive_reg  <= 1'b0;
        dataDrive_reg <= 1'b0;
      end else begin
        case (state_reg)
          // shift in address or data bits on scl rise
          ST_ADDR, ST_WRX: begin
            if (sclRise) begin
              shift_reg  <= rxByte;
              bitCnt_reg <= bitCnt_reg + 3'd1;
            end
            if (byteDone && state_reg == ST_ADDR) begin
              if (rxByte[7:1] == `MDI_TARGET_ADDR) begin
                readDir_reg   <= rxByte[0];
                firstByte_reg <= !rxByte[0];
                state_reg     <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (byteDone) begin
              state_reg <= ST_ACK;
              if (firstByte_reg) begin
                regPtr_reg    <= rxByte;
                firstByte_reg <= 1'b0;
              end else begin
                regPtr_reg <= regPtr_reg + 8'h01;
              end
            end
          end
          // ack slot, then hand over to write or read
          ST_ACK: begin
            if (sclFall && !ackDrive_reg) begin
              ackDrive_reg <= 1'b1;
            end else if (sclFall && ackDrive_reg) begin
              ackDrive_reg <= 1'b0;
              bitCnt_reg   <= 3'd0;
              if (readDir_reg) begin
                shift_reg     <= readByte;
                dataDrive_reg <= 1'b1;
                state_reg     <= ST_RDX;
              end else begin
                state_reg <= ST_WRX;
              end
            end
          end
          // read bits change after the synced scl fall
          ST_RDX: begin
            if (sclFall) begin
              shift_reg  <= {shift_reg[6:0], 1'b0};
              bitCnt_reg <= bitCnt_reg + 3'd1;
              if (bitCnt_reg == 3'd7) begin
                dataDrive_reg <= 1'b0;
                state_reg     <= ST_RACK;
              end
            end
          end
          // controller ack continues, nack ends the read
          ST_RACK: begin
            if (sclRise) begin
              if (sda) begin
                state_reg <= ST_IDLE;
              end else begin
                regPtr_reg <= regPtr_reg + 8'h01;
                state_reg  <= ST_ACK;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end

      // register writes
      // a write to any other register forgets the key
      if (wrStrobe) begin
        keyOk_reg <= 1'b0;
        if (regPtr_reg >= `MDI_PARAM_FIRST && regPtr_reg <= `MDI_PARAM_LAST) begin
          if (unlock_reg) begin
            params_reg[paramIdx] <= rxByte;
          end
        end else if (regPtr_reg == `MDI_DEV_CTRL_ADDR) begin
          devCtrl_reg <= rxByte;
          keyOk_reg   <= (rxByte == `MDI_PROGRAM_KEY);
        end else if (regPtr_reg == `MDI_NV_CTRL_ADDR) begin
          unlock_reg <= rxByte[`MDI_UNLOCK_BIT];
          if (rxByte[`MDI_STORE_BIT] && keyOk_reg && nvState_reg == NV_IDLE) begin
            storeTrig_reg <= 1'b1;
            nvState_reg   <= NV_STORE;
            nvIdx_reg     <= 4'h0;
            nvTimer_reg   <= 32'h0;
          end
          if (rxByte[`MDI_RELOAD_BIT]) begin
            reloadTrig_reg <= 1'b1;
          end
        end
      end

      // nonvolatile sequencer
      // load strobe lags the memory read by one cycle
      nvLoadWr_reg  <= 1'b0;
      if (nvLoadWr_reg) begin
        params_reg[nvLoadIdx_reg] <= nvRdData;
      end
      case (nvState_reg)
        // reload waits until the write that requests it is over
        NV_IDLE: begin
          if (reloadTrig_reg && !(wrStrobe && regPtr_reg == `MDI_NV_CTRL_ADDR)) begin
            nvState_reg <= NV_LOAD;
            nvIdx_reg   <= 4'h0;
          end
        end
        // one cell a cycle, in address order
        NV_LOAD: begin
          nvLoadWr_reg  <= 1'b1;
          nvLoadIdx_reg <= nvIdx_reg;
          nvIdx_reg     <= nvIdx_reg + 4'h1;
          if (nvIdx_reg == 4'hB) begin
            nvState_reg    <= NV_IDLE;
            // a reload request in the last load cycle wins over the clear
            reloadTrig_reg <= wrStrobe && regPtr_reg == `MDI_NV_CTRL_ADDR &&
                              rxByte[`MDI_RELOAD_BIT]; // self clear
          end
        end
        // copy twelve cells, then hold busy for the program time
        NV_STORE: begin
          if (nvIdx_reg < 4'hC) begin
            nvIdx_reg <= nvIdx_reg + 4'h1;
          end else if (nvTimer_reg >= STORE_CYCLES - 1) begin
            nvState_reg   <= NV_IDLE;
            storeTrig_reg <= 1'b0; // self clear after program time
          end else begin
            nvTimer_reg <= nvTimer_reg + 32'h1;
          end
        end
        default: nvState_reg <= NV_IDLE;
      endcase
    end
  end


  // pin drive: oe low pulls the line
  // data bits change only after the synced clock fall
  wire txBit = dataDrive_reg ? shift_reg[7] : 1'b1;
  assign sdaOut  = 1'b0;
  assign sdaOe_n = !(ackDrive_reg || (dataDrive_reg && !txBit));


  // live parameters drive the motor logic
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : gParam
      assign motorParams[g*8 +: 8] = params_reg[g];
    end
  endgenerate
  // busy mirrors the store trigger bit
  assign storeBusy = storeTrig_reg;
endmodule
`default_nettype wire

// >>> sim/mdi_i2c_props.sv
/*
  checker for the i2c target: pin use, store timing, register stability.
  assumes it is bound to mdi_i2c_target and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module mdi_i2c_props #(
  parameter STORE_CYCLES = 50
) (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe_n,
  input wire logic [7:0]  supplyLevelReading,
  input wire logic [95:0] motorParams,
  input wire logic        storeBusy
);
  logic [31:0] busyCnt;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // cycles spent in the current store
  always @(posedge clock) begin
    if (sys_rst || !storeBusy)
      busyCnt <= 32'h0;
    else if (clkEn)
      busyCnt <= busyCnt + 32'h1;
  end
  sequence sBusyStart;
    $rose(storeBusy);
  endsequence
  sequence sBusyHold;
    storeBusy [*8];
  endsequence
  a_pin_open_drain: assert property (sdaOut == 1'b0)
    else $error("sda pin driven high");
  a_reset_no_drive: assert property ($fell(sys_rst) |-> sdaOe_n && !storeBusy)
    else $error("pin or store active at reset release");
  a_sda_stable_high: assert property (sclIn && $past(sclIn) && $past(sclIn, 2) |-> $stable(sdaOe_n))
    else $error("sda moved while scl high");
  a_busy_short_hold: assert property (sBusyStart |-> ##1 sBusyHold)
    else $error("store ended early");
  a_busy_min_len: assert property ($fell(storeBusy) |-> $past(busyCnt) >= STORE_CYCLES)
    else $error("store shorter than its time");
  a_busy_max_len: assert property (busyCnt <= STORE_CYCLES + 20)
    else $error("store trigger never cleared");
  a_store_keeps_regs: assert property (storeBusy && $past(storeBusy) |-> $stable(motorParams))
    else $error("parameters moved during store");
  a_freeze_when_off: assert property (!clkEn |=> $stable(motorParams) && $stable(storeBusy))
    else $error("state moved while disabled");
endmodule
bind mdi_i2c_target mdi_i2c_props #(.STORE_CYCLES(STORE_CYCLES)) i_props (
  .clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .supplyLevelReading(supplyLevelReading),
  .motorParams(motorParams), .storeBusy(storeBusy));
`default_nettype wire

// >>> sim/mdi_i2c_host.sv
/*
  i2c controller model: start, stop, byte write and byte read.
  assumes sda has a pull-up; acts on falling clock edges, 400 ns scl period.
*/
`timescale 1ns/1ps
`default_nettype none
module mdi_i2c_host (
  input  wire logic clock,
  input  wire logic sdaBus,
  output var logic  scl,
  output var logic  sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // a quarter of the link period
  task automatic q;
    repeat (2) @(negedge clock);
  endtask
  // start: sda falls while scl high
  task automatic start;
    sdaLow = 1'b0;
    scl = 1'b1;
    q;
    sdaLow = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask
  // stop: sda released while scl high, line floats to the pull-up
  task automatic stop;
    sdaLow = 1'b1;
    q;
    scl = 1'b1;
    q;
    sdaLow = 1'b0;
    q;
  endtask
  // low quarter, high half, low quarter, 400 ns in all; sda moves only while scl is low
  task automatic bitOut(input logic b);
    sdaLow = !b;
    q;
    scl = 1'b1;
    q;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic bitIn(output logic b);
    sdaLow = 1'b0;
    q;
    scl = 1'b1;
    q;
    b = sdaBus;
    q;
    scl = 1'b0;
    q;
  endtask
  // msb first, address byte carries direction in bit 0
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(a);
    ack = !a;
  endtask
  task automatic rdByte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(nack);
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
  self-checking bench: unlock, load, store, reload and read back.
  assumes mdi_i2c_target with a short store count and a 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock, sys_rst, clkEn, scl, hostLow, ack;
  logic [7:0]  supply, rdVal;
  logic [95:0] expParams;
  wire         sdaBus, sdaOut, sdaOe_n, storeBusy;
  wire  [95:0] params;
  int          failures, n_tests;
  // pulled-up bus: either party may pull it low
  assign sdaBus = !hostLow && sdaOe_n;
  mdi_i2c_target #(.STORE_CYCLES(50)) i_dut (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
    .sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .supplyLevelReading(supply), .motorParams(params), .storeBusy(storeBusy));
  mdi_i2c_host i_host (.clock(clock), .sdaBus(sdaBus), .scl(scl), .sdaLow(hostLow));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one write transaction: address, pointer, data
  task automatic wr(input logic [7:0] ad, input logic [7:0] rg, input logic [7:0] d);
    i_host.start;
    i_host.wrByte(ad, ack);
    chk(ack, ad == 8'hA4);
    i_host.wrByte(rg, ack);
    i_host.wrByte(d, ack);
    i_host.stop;
  endtask
  // pointer write, stop, then one-byte read
  task automatic rd(input logic [7:0] rg);
    i_host.start;
    i_host.wrByte(8'hA4, ack);
    i_host.wrByte(rg, ack);
    i_host.stop;
    i_host.start;
    i_host.wrByte(8'hA5, ack);
    i_host.rdByte(rdVal, 1'b1);
    i_host.stop;
  endtask
  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    supply = 8'h9C;
    failures = 0;
    n_tests = 0;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (20) @(negedge clock);
    wr(8'hA0, 8'h03, 8'h80);
    wr(8'hA4, 8'h03, 8'h80);
    for (int i = 0; i < 12; i++) begin
      wr(8'hA4, 8'h20 + i[7:0], 8'h30 + i[7:0]);
      expParams[8*i+:8] = 8'h30 + i[7:0];
    end
    chk(params, expParams);
    rd(8'h2B);
    chk(rdVal, 8'h3B);
    // key followed by another write is forgotten
    wr(8'hA4, 8'h02, 8'hB6);
    wr(8'hA4, 8'h20, 8'h55);
    expParams[7:0] = 8'h55;
    wr(8'hA4, 8'h03, 8'h50);
    chk(storeBusy, 1'b0);
    wr(8'hA4, 8'h02, 8'hB6);
    wr(8'hA4, 8'h03, 8'h50);
    chk(storeBusy, 1'b1);
    for (int k = 0; storeBusy !== 1'b0; k++) begin
      if (k == 200) begin
        failures++;
        finish_test;
      end
      @(negedge clock);
    end
    rd(8'h03);
    chk(rdVal[6], 1'b0);
    wr(8'hA4, 8'h20, 8'h77);
    chk(params, expParams);
    wr(8'hA4, 8'h03, 8'h80);
    wr(8'hA4, 8'h21, 8'h99);
    wr(8'hA4, 8'h03, 8'hA0);
    repeat (30) @(negedge clock);
    chk(params, expParams);
    rd(8'h03);
    chk(rdVal[5], 1'b0);
    rd(8'h1A);
    chk(rdVal, 8'h9C);
    clkEn = 1'b0;
    repeat (5) @(negedge clock);
    clkEn = 1'b1;
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (30) @(negedge clock);
    chk(params, expParams);
    finish_test;
  end
endmodule
`default_nettype wire
